// file: logic/cycle_timer.sv
// fixed-cycle countdown timer with shared open-drain interrupt, APB registers
// assumes link_clk is the serial clock pin, asynchronous to pclk
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module cycle_timer #(
  parameter int unsigned DIV_FAST_CYC =
    cycle_timer_pkg::SRC_FAST_PERIOD_NS / cycle_timer_pkg::PCLK_PERIOD_NS,
  parameter int unsigned REL_SLOW_CYC =
    cycle_timer_pkg::REL_SLOW_NS / cycle_timer_pkg::PCLK_PERIOD_NS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cycle_timer_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial link clock pin
  input wire logic link_clk,
  // open-drain interrupt pin, active low
  output logic irq_n_out,
  output logic irq_n_oe
);

  localparam logic [cycle_timer_pkg::DIV_W-1:0] DIV_LAST =
    cycle_timer_pkg::DIV_W'(DIV_FAST_CYC - 1);
  localparam logic [cycle_timer_pkg::REL_W-1:0] REL_FAST_LAST =
    cycle_timer_pkg::REL_W'(cycle_timer_pkg::REL_FAST_CYC - 1);
  localparam logic [cycle_timer_pkg::REL_W-1:0] REL_SLOW_LAST =
    cycle_timer_pkg::REL_W'(REL_SLOW_CYC - 1);
  localparam logic [cycle_timer_pkg::CNT_W-1:0] CNT_ONE = 12'h001;

  cycle_timer_pkg::state_s st;
  cycle_timer_pkg::state_s nx;
  logic setup_cycle;
  logic access_done;
  logic wr_done;
  logic hit_lo;
  logic hit_hi;
  logic hit_ext;
  logic hit_flags;
  logic hit_irq;
  logic te_rise;
  logic te_clear;
  logic link_fall;
  logic tick_fast;
  logic tick_64;
  logic tick_sec;
  logic tick_min;
  logic src_tick;
  logic fire;
  logic [cycle_timer_pkg::CNT_W-1:0] read_cnt;

  // ****************************************
  // decode and strobes
  // ****************************************

  // one wait state so that prdata and pready come from flops
  assign setup_cycle = psel & penable & ~st.apb.pready;
  assign access_done = psel & penable & st.apb.pready;
  assign wr_done = access_done & pwrite;
  assign hit_lo = paddr == cycle_timer_pkg::ADDR_PRESET_LO;
  assign hit_hi = paddr == cycle_timer_pkg::ADDR_PRESET_HI;
  assign hit_ext = paddr == cycle_timer_pkg::ADDR_EXT_CTRL;
  assign hit_flags = paddr == cycle_timer_pkg::ADDR_FLAGS;
  assign hit_irq = paddr == cycle_timer_pkg::ADDR_IRQ_CTRL;
  assign te_rise = wr_done & hit_ext & pwdata[cycle_timer_pkg::TIMER_ENABLE_BIT]
    & ~st.ctl.timer_enable;
  assign te_clear = wr_done & hit_ext & ~pwdata[cycle_timer_pkg::TIMER_ENABLE_BIT];
  // edge detect reads only the second and third flops, never the first
  assign link_fall = st.lk_prev & ~st.lk_sync2;

  // free-running prescaler ticks; not aligned to the start of a countdown
  assign tick_fast = st.pre.div == DIV_LAST;
  assign tick_64 = tick_fast & (st.pre.sub64 == cycle_timer_pkg::LAST_OF_64);
  assign tick_sec = tick_fast & (st.pre.sub4096 == cycle_timer_pkg::LAST_OF_4096);
  assign tick_min = tick_sec & (st.pre.sub60 == cycle_timer_pkg::LAST_SECOND);

  assign read_cnt = st.ctl.timer_enable ? st.count : st.ctl.preset;

  // ****************************************
  // next-state logic
  // ****************************************

  // whole block state computed here, registered below
  always_comb begin
    nx = st;
    fire = 1'b0;
    src_tick = 1'b0;
    // link clock pin through two flops, third for edge finding
    nx.lk_sync1 = link_clk;
    nx.lk_sync2 = st.lk_sync1;
    nx.lk_prev = st.lk_sync2;

    // prescaler chain
    nx.pre.div = tick_fast ? '0 : cycle_timer_pkg::DIV_W'(st.pre.div + 1'b1);
    if (tick_fast) begin
      nx.pre.sub64 = 6'(st.pre.sub64 + 1'b1);
      nx.pre.sub4096 = 12'(st.pre.sub4096 + 1'b1);
    end
    if (tick_sec) begin
      nx.pre.sub60 = tick_min ? '0 : 6'(st.pre.sub60 + 1'b1);
    end

    unique case (st.ctl.source_select)
      cycle_timer_pkg::SEL_4096HZ: src_tick = tick_fast;
      cycle_timer_pkg::SEL_64HZ: src_tick = tick_64;
      cycle_timer_pkg::SEL_1HZ: src_tick = tick_sec;
      cycle_timer_pkg::SEL_MINUTE: src_tick = tick_min;
    endcase

    // apb answer one cycle after the access phase opens
    nx.apb.pready = setup_cycle;
    nx.apb.prdata = '0;
    nx.apb.pslverr = setup_cycle & ~(hit_lo | hit_hi | hit_ext | hit_flags | hit_irq);
    if (setup_cycle & ~pwrite) begin
      if (hit_lo) begin
        nx.apb.prdata[7:0] = read_cnt[7:0];
      end
      if (hit_hi) begin
        nx.apb.prdata[3:0] = read_cnt[11:8];
      end
      if (hit_ext) begin
        nx.apb.prdata[cycle_timer_pkg::TIMER_ENABLE_BIT] = st.ctl.timer_enable;
        nx.apb.prdata[cycle_timer_pkg::SOURCE_SELECT_HI_BIT] = st.ctl.source_select[1];
        nx.apb.prdata[cycle_timer_pkg::SOURCE_SELECT_LO_BIT] = st.ctl.source_select[0];
      end
      if (hit_flags) begin
        nx.apb.prdata[cycle_timer_pkg::TIMER_EVENT_FLAG_BIT] = st.timer_event_flag;
      end
      if (hit_irq) begin
        nx.apb.prdata[cycle_timer_pkg::TIMER_IRQ_ENABLE_BIT] = st.ctl.timer_irq_enable;
      end
    end

    // register writes take effect at the completing edge only
    if (wr_done & hit_lo) begin
      nx.ctl.preset[7:0] = pwdata[7:0];
    end
    if (wr_done & hit_hi) begin
      nx.ctl.preset[11:8] = pwdata[3:0];
    end
    if (wr_done & hit_ext) begin
      nx.ctl.timer_enable = pwdata[cycle_timer_pkg::TIMER_ENABLE_BIT];
      nx.ctl.source_select[1] = pwdata[cycle_timer_pkg::SOURCE_SELECT_HI_BIT];
      nx.ctl.source_select[0] = pwdata[cycle_timer_pkg::SOURCE_SELECT_LO_BIT];
    end
    if (wr_done & hit_irq) begin
      nx.ctl.timer_irq_enable = pwdata[cycle_timer_pkg::TIMER_IRQ_ENABLE_BIT];
    end

    // countdown sequencer
    unique case (st.run)
      cycle_timer_pkg::RUN_IDLE: begin
        // start request waits for sampled link edge
        if (te_rise) begin
          nx.run = cycle_timer_pkg::RUN_ARMED;
        end
      end
      cycle_timer_pkg::RUN_ARMED: begin
        if (te_clear) begin
          nx.run = cycle_timer_pkg::RUN_IDLE;
        end else if (link_fall) begin
          nx.count = st.ctl.preset;
          nx.run = cycle_timer_pkg::RUN_COUNT;
        end
      end
      cycle_timer_pkg::RUN_COUNT: begin
        if (te_clear) begin
          nx.run = cycle_timer_pkg::RUN_IDLE;
        end else if (src_tick && st.count != '0) begin
          // first tick lands anywhere in a period
          if (st.count == CNT_ONE) begin
            // fire and reload on 1 to 0
            fire = 1'b1;
            nx.count = st.ctl.preset;
          end else begin
            nx.count = cycle_timer_pkg::CNT_W'(st.count - 1'b1);
          end
        end
      end
    endcase

    if (wr_done & hit_flags & ~pwdata[cycle_timer_pkg::TIMER_EVENT_FLAG_BIT]) begin
      nx.timer_event_flag = 1'b0;
    end
    // set wins over a same-cycle clear
    if (fire) begin
      nx.timer_event_flag = 1'b1;
    end

    if (fire & st.ctl.timer_irq_enable) begin
      nx.irq_oe = 1'b1;
      nx.rel = (st.ctl.source_select == cycle_timer_pkg::SEL_4096HZ) ?
        REL_FAST_LAST : REL_SLOW_LAST;
    end else if (st.irq_oe) begin
      // auto release after the hold time
      if (st.rel == '0) begin
        nx.irq_oe = 1'b0;
      end else begin
        nx.rel = cycle_timer_pkg::REL_W'(st.rel - 1'b1);
      end
    end
    // irq enable low releases the pin
    if (~nx.ctl.timer_irq_enable) begin
      nx.irq_oe = 1'b0;
    end
    // only pulls low, never drives high, so others share it
    nx.irq_level = 1'b0;
  end

  // ****************************************
  // state register and outputs
  // ****************************************

  // single register for the whole block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= cycle_timer_pkg::STATE_RESET;
    end else begin
      st <= nx;
    end
  end

  // outputs taken straight from state flops
  assign prdata = st.apb.prdata;
  assign pready = st.apb.pready;
  assign pslverr = st.apb.pslverr;
  assign irq_n_out = st.irq_level;
  assign irq_n_oe = st.irq_oe;

  // ****************************************
  // assertions
  // ****************************************

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_preset_read;
    (setup_cycle && !pwrite && hit_lo && !st.ctl.timer_enable)
      |=> (prdata[7:0] == $past(st.ctl.preset[7:0]) && pready);
  endproperty
  a_preset_read: assert property (p_preset_read) else $error("preset not read back");

  property p_stop_keeps_pin;
    (te_clear && st.irq_oe && st.ctl.timer_irq_enable && st.rel != '0 && !(wr_done && hit_irq))
      |=> (irq_n_oe && st.run == cycle_timer_pkg::RUN_IDLE);
  endproperty
  a_stop_keeps_pin: assert property (p_stop_keeps_pin) else $error("stop released pin");

  property p_start_load;
    (st.run == cycle_timer_pkg::RUN_ARMED && link_fall && !te_clear)
      |=> (st.run == cycle_timer_pkg::RUN_COUNT && st.count == $past(st.ctl.preset));
  endproperty
  a_start_load: assert property (p_start_load) else $error("countdown not started from preset");

  property p_flag_set;
    fire |=> st.timer_event_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("event flag not set");

  property p_flag_one_ignored;
    (wr_done && hit_flags && pwdata[cycle_timer_pkg::TIMER_EVENT_FLAG_BIT] && st.timer_event_flag)
      |=> st.timer_event_flag;
  endproperty
  a_flag_one_ignored: assert property (p_flag_one_ignored) else $error("flag cleared by one");

  property p_clear_keeps_pin;
    (wr_done && hit_flags && st.irq_oe && st.ctl.timer_irq_enable && st.rel != '0)
      |=> irq_n_oe;
  endproperty
  a_clear_keeps_pin: assert property (p_clear_keeps_pin) else $error("flag clear released pin");

  property p_event_drives;
    (fire && st.ctl.timer_irq_enable && !(wr_done && hit_irq)) |=> (irq_n_oe && !irq_n_out);
  endproperty
  a_event_drives: assert property (p_event_drives) else $error("event did not pull pin");

  property p_disabled_released;
    !st.ctl.timer_irq_enable |=> !irq_n_oe;
  endproperty
  a_disabled_released: assert property (p_disabled_released) else $error("pin low with irq off");

  property p_zero_silent;
    (st.run == cycle_timer_pkg::RUN_COUNT && st.count == '0) |-> !fire ##1 st.count == '0;
  endproperty
  a_zero_silent: assert property (p_zero_silent) else $error("zero setting fired");

  property p_reload;
    fire |=> (st.count == $past(st.ctl.preset) && st.run == cycle_timer_pkg::RUN_COUNT);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload after event");

  property p_fast_release;
    (fire && st.ctl.timer_irq_enable
      && st.ctl.source_select == cycle_timer_pkg::SEL_4096HZ) |=> (st.rel == REL_FAST_LAST);
  endproperty
  a_fast_release: assert property (p_fast_release) else $error("wrong release time");

  c_start: cover property (st.run == cycle_timer_pkg::RUN_ARMED ##1
    st.run == cycle_timer_pkg::RUN_COUNT);
  c_fire_irq: cover property (fire && st.ctl.timer_irq_enable);
  c_auto_release: cover property ($fell(irq_n_oe) && st.ctl.timer_irq_enable);
  c_flag_clear: cover property ($fell(st.timer_event_flag));

endmodule : cycle_timer

// file: logic/cycle_timer_pkg.sv
// constants, field layout and state types for the fixed-cycle timer block
// assumes a 20 MHz register clock and an APB master with 32-bit data
package cycle_timer_pkg;

  // ****************************************
  // register map: index and byte address
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] IDX_PRESET_LO = 8'h0B;
  localparam logic [ADDR_W-1:0] IDX_PRESET_HI = 8'h0C;
  localparam logic [ADDR_W-1:0] IDX_EXT_CTRL = 8'h0D;
  localparam logic [ADDR_W-1:0] IDX_FLAGS = 8'h0E;
  localparam logic [ADDR_W-1:0] IDX_IRQ_CTRL = 8'h0F;
  localparam logic [ADDR_W-1:0] ADDR_PRESET_LO = {IDX_PRESET_LO[5:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PRESET_HI = {IDX_PRESET_HI[5:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_EXT_CTRL = {IDX_EXT_CTRL[5:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = {IDX_FLAGS[5:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CTRL = {IDX_IRQ_CTRL[5:0], 2'h0};

  // ****************************************
  // field positions
  // ****************************************
  localparam int TIMER_ENABLE_BIT = 4;
  localparam int TIMER_EVENT_FLAG_BIT = 4;
  localparam int TIMER_IRQ_ENABLE_BIT = 4;
  localparam int SOURCE_SELECT_LO_BIT = 0;
  localparam int SOURCE_SELECT_HI_BIT = 1;
  localparam int CNT_W = 12;
  localparam int REL_W = 18;
  localparam int DIV_W = 13;

  // source select codes
  localparam logic [1:0] SEL_4096HZ = 2'h0;
  localparam logic [1:0] SEL_64HZ = 2'h1;
  localparam logic [1:0] SEL_1HZ = 2'h2;
  localparam logic [1:0] SEL_MINUTE = 2'h3;

  // ****************************************
  // times and derived counts
  // ****************************************
  localparam int PCLK_PERIOD_NS = 50;
  localparam int SRC_FAST_PERIOD_NS = 244140;
  localparam int REL_FAST_NS = 122000;
  localparam int REL_SLOW_NS = 7813000;
  localparam int REL_FAST_CYC = REL_FAST_NS / PCLK_PERIOD_NS;
  localparam logic [5:0] LAST_OF_64 = 6'h3F;
  localparam logic [11:0] LAST_OF_4096 = 12'hFFF;
  localparam logic [5:0] LAST_SECOND = 6'h3B;

  // ****************************************
  // state types
  // ****************************************
  typedef enum logic [1:0] {RUN_IDLE, RUN_ARMED, RUN_COUNT} run_e;

  typedef struct packed {
    logic timer_enable;
    logic timer_irq_enable;
    logic [1:0] source_select;
    logic [CNT_W-1:0] preset;
  } ctrl_s;

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic [5:0] sub64;
    logic [11:0] sub4096;
    logic [5:0] sub60;
  } prescale_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_out_s;

  typedef struct packed {
    ctrl_s ctl;
    prescale_s pre;
    apb_out_s apb;
    run_e run;
    logic [CNT_W-1:0] count;
    logic timer_event_flag;
    logic irq_oe;
    logic irq_level;
    logic [REL_W-1:0] rel;
    logic lk_sync1;
    logic lk_sync2;
    logic lk_prev;
  } state_s;

  localparam state_s STATE_RESET = '0;

endpackage : cycle_timer_pkg

// file: test/cycle_timer_partner.sv
// far-side model: serial clock frames from the host and the shared interrupt wire
// assumes the bench raises frame_req once for each serial frame it wants sent
`timescale 1ns/100ps
module cycle_timer_partner (
  // bench control
  input wire logic frame_req,
  input wire logic other_low,
  // device pins
  input wire logic irq_n_out,
  input wire logic irq_n_oe,
  output logic link_clk,
  output logic irq_n
);
  // shared open-drain wire
  // pull-up shows only when nobody pulls low; a second source may hold it low
  assign irq_n = (irq_n_oe ? irq_n_out : 1'b1) & ~other_low;

  // host completes frame
  // serial clock idles high and runs only inside a frame of eight bits
  initial begin
    link_clk = 1'b1;
  end
  always @(posedge frame_req) begin
    #37;
    repeat (8) begin
      link_clk = 1'b0;
      #200;
      link_clk = 1'b1;
      #200;
    end
  end
endmodule : cycle_timer_partner

// file: test/fixed_cycle_timer_interrupt_tb.sv
// self-checking bench for the fixed-cycle timer: apb tasks, queued notes, link frames
// assumes cycle_timer_pkg, cycle_timer and the partner model are compiled first
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module fixed_cycle_timer_interrupt_tb;
  // short counts keep the slow rates inside the run budget
  localparam int DIVF = 8;
  localparam int RELS = 20;
  localparam logic [7:0] A_LO = cycle_timer_pkg::ADDR_PRESET_LO;
  localparam logic [7:0] A_HI = cycle_timer_pkg::ADDR_PRESET_HI;
  localparam logic [7:0] A_EXT = cycle_timer_pkg::ADDR_EXT_CTRL;
  localparam logic [7:0] A_FLG = cycle_timer_pkg::ADDR_FLAGS;
  localparam logic [7:0] A_IRQ = cycle_timer_pkg::ADDR_IRQ_CTRL;
  logic pclk, presetn, psel, penable, pwrite, frame_req, other_low;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, link_clk, irq_n_out, irq_n_oe, irq_n;
  logic [33:0] q[$];
  logic [33:0] e;
  int fails, samples_checked, cyc;

  // ****************************************
  // instances
  // ****************************************
  cycle_timer #(.DIV_FAST_CYC(DIVF), .REL_SLOW_CYC(RELS)) dut_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_clk(link_clk), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
  cycle_timer_partner far_u (.frame_req(frame_req), .other_low(other_low),
    .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .link_clk(link_clk), .irq_n(irq_n));

  // ****************************************
  // clock, timeout, monitor
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // longest path is two one-second intervals plus the fast rows
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      fails++;
      end_sim();
    end
  end
  // oldest note against each completed transfer; bit 33 asks for a data check
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      e = q.pop_front();
      `CHK(pslverr, e[32])
      if (e[33]) `CHK(prdata, e[31:0])
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [33:0] x);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    q.push_back(x);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, {2'b00, 32'h0});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, {2'b10, x});
  endtask : rd
  // edges until the pin enable shows v
  task automatic wait_oe(input logic v, output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (irq_n_oe !== v);
  endtask : wait_oe
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    int n, h, l, p, per;
    logic [11:0] rp;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    frame_req = 1'b0;
    other_low = 1'b0;
    presetn = 1'b0;
    void'($urandom(32'hea5b7b98));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, unmapped place, select codes, preset readback
    for (int i = 0; i < 5; i++) rd(A_LO + 8'(4 * i), 32'h0);
    apb(1'b1, 8'h00, 32'hFF, {2'b01, 32'h0});
    apb(1'b0, 8'h00, 32'h0, {2'b11, 32'h0});
    for (int s = 0; s < 4; s++) begin
      wr(A_EXT, 32'(s));
      rd(A_EXT, 32'(s));
    end
    rp = 12'($urandom_range(4095, 1));
    wr(A_LO, {24'h0, rp[7:0]});
    wr(A_HI, {28'h0, rp[11:8]});
    rd(A_LO, {24'h0, rp[7:0]});
    rd(A_HI, {28'h0, rp[11:8]});
    $display("test registers done");
    // the 4096 Hz, 64 Hz and 1 Hz rates: start from preset, first interval, release time, reload interval
    for (int i = 0; i < 3; i++) begin
      p = (i == 0) ? 400 : 3 - i;
      per = DIVF << (6 * i);
      wr(A_EXT, 32'(i));
      wr(A_IRQ, 32'h0);
      wr(A_LO, 32'(p & 255));
      wr(A_HI, 32'(p >> 8));
      wr(A_FLG, 32'h0);
      wr(A_IRQ, 32'h10);
      wr(A_EXT, 32'h10 | 32'(i));
      repeat (40) @(posedge pclk);
      `CHK(irq_n_oe, 1'b0)
      frame_req <= 1'b1;
      @(negedge link_clk);
      wait_oe(1'b1, n);
      frame_req <= 1'b0;
      `CHK(n >= (p - 1) * per && n <= p * per + 8, 1'b1)
      wait_oe(1'b0, h);
      `CHK(h, (i == 0) ? cycle_timer_pkg::REL_FAST_CYC : RELS)
      wait_oe(1'b1, l);
      `CHK(h + l, p * per)
      rd(A_FLG, 32'h10);
      wr(A_FLG, 32'h10);
      rd(A_FLG, 32'h10);
      wr(A_FLG, 32'h0);
      rd(A_FLG, 32'h0);
      $display("test rate %0d done", i);
    end
    // masked events, then enable, disable, flag clear and mask while pin is low
    wr(A_EXT, 32'h0);
    wr(A_IRQ, 32'h0);
    wr(A_LO, 32'h3);
    wr(A_HI, 32'h0);
    wr(A_FLG, 32'h0);
    wr(A_EXT, 32'h10);
    frame_req <= 1'b1;
    repeat (80) @(posedge pclk);
    frame_req <= 1'b0;
    `CHK(irq_n_oe, 1'b0)
    rd(A_FLG, 32'h10);
    wr(A_IRQ, 32'h10);
    wait_oe(1'b1, n);
    `CHK(n <= 3 * DIVF + 2 && irq_n === 1'b0, 1'b1)
    wr(A_EXT, 32'h0);
    // let the committing edge pass before looking at the pin
    @(posedge pclk);
    `CHK(irq_n_oe, 1'b1)
    wr(A_FLG, 32'h0);
    @(posedge pclk);
    `CHK(irq_n_oe, 1'b1)
    wr(A_IRQ, 32'h0);
    repeat (2) @(posedge pclk);
    `CHK(irq_n_oe, 1'b0)
    `CHK(irq_n, 1'b1)
    other_low <= 1'b1;
    @(posedge pclk);
    `CHK(irq_n, 1'b0)
    other_low <= 1'b0;
    $display("test irq control done");
    // zero setting: a started countdown must never raise the flag
    wr(A_LO, 32'h0);
    wr(A_FLG, 32'h0);
    wr(A_EXT, 32'h10);
    frame_req <= 1'b1;
    repeat (80) @(posedge pclk);
    frame_req <= 1'b0;
    rd(A_FLG, 32'h0);
    $display("test zero setting done");
    end_sim();
  end
endmodule : fixed_cycle_timer_interrupt_tb
